// file: fpes_pkg.sv
// Operation
// - Program: setup 40H/10H, then data, same address
// - Chip erase: 30H, D0H; bit 5 failure
// - Lock set: 60H, 01H at block; bit 4
// - Clear locks: 60H, D0H; bit 5 failure
// - After error, clear status before next operation
// - Write FFH afterwards to return read-array
// - Full check per operation or per series
// - Lock several blocks by repeating pair
// - Poll bit 7 until ready for completion
// - Ignore bits 6..0 while bit 7 low
package fpes_pkg;

    // ****************************************
    // Clock and pin timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int WE_LOW_NS = 50;
    localparam int RECOV_NS = 30;
    localparam int RD_ACC_NS = 100;
    localparam logic [7:0] WE_LOW_CYC = 8'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RECOV_CYC = 8'((RECOV_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RD_ACC_CYC = 8'((RD_ACC_NS * CLK_MHZ + 999) / 1000);

    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    // ****************************************
    // Flash command bytes
    // ****************************************
    localparam logic [7:0] FL_PROG_SETUP = 8'h40;
    localparam logic [7:0] FL_PROG_SETUP_ALT = 8'h10;
    localparam logic [7:0] FL_ERASE_ALL_SETUP = 8'h30;
    localparam logic [7:0] FL_CONFIRM = 8'hd0;
    localparam logic [7:0] FL_LOCK_SETUP = 8'h60;
    localparam logic [7:0] FL_LOCK_SET = 8'h01;
    localparam logic [7:0] FL_READ_ARRAY = 8'hff;
    localparam logic [7:0] FL_READ_STATUS = 8'h70;

    // status_reg bit positions
    localparam int SR_READY = 7;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_WRITE_ERR = 4;
    localparam int SR_VPP_LOW = 3;
    localparam int SR_PROTECT = 1;

    // Host error flag positions
    localparam int ERR_VPP = 0;
    localparam int ERR_PROT = 1;
    localparam int ERR_SEQ = 2;
    localparam int ERR_OP = 3;

    // ****************************************
    // Software register map
    // ****************************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_INT_STAT = 8'h14;
    localparam logic [7:0] REG_INT_CLR = 8'h18;
    localparam logic [7:0] REG_INT_EN = 8'h1c;

    localparam int CMD_CHECK = 4;
    localparam int CMD_EXIT = 5;
    localparam int CMD_ALT = 6;

    localparam int ST_BUSY = 0;
    localparam int ST_ERR_PEND = 1;
    localparam int ST_ERRS_LSB = 4;
    localparam int ST_SR_LSB = 8;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_REFUSED = 2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_PROG = 4'h1,
        OP_ERASE_ALL = 4'h2,
        OP_LOCK_SET = 4'h3,
        OP_LOCK_CLR = 4'h4,
        OP_READ_MODE = 4'h5,
        OP_CLR_STATUS = 4'h6,
        OP_READ_STATUS = 4'h7,
        OP_ARRAY_READ = 4'h8
    } fpes_op_t;

endpackage : fpes_pkg

// file: fpes_bus_cycle.sv
module fpes_bus_cycle (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic req_wr,
    input wire logic [20:0] req_addr,
    input wire logic [15:0] req_data,
    input wire logic [15:0] fl_dq_i,
    output logic done,
    output logic [15:0] rdata,
    output logic [20:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe_n,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);

    typedef enum logic [2:0] {
        BC_IDLE = 3'b001,
        BC_ACT = 3'b010,
        BC_REC = 3'b100
    } fpes_bc_st_t;

    typedef struct packed {
        fpes_bc_st_t st;
        logic wr;
        logic [7:0] cnt;
        logic done;
        logic [15:0] rdata;
        logic [20:0] addr;
        logic [15:0] dq;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fpes_bc_t;

    fpes_bc_t s_r;
    fpes_bc_t s_nxt;

    // ****************************************
    // One flash bus cycle: strobe, then recovery
    // ****************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            BC_IDLE:
            begin
                if (req)
                begin
                    s_nxt.wr = req_wr;
                    s_nxt.addr = req_addr;
                    s_nxt.dq = req_data;
                    s_nxt.ce_n = 1'b0;
                    s_nxt.we_n = ~req_wr;
                    s_nxt.oe_n = req_wr;
                    s_nxt.dq_oe_n = ~req_wr;
                    s_nxt.cnt = (req_wr ? fpes_pkg::WE_LOW_CYC
                                        : fpes_pkg::RD_ACC_CYC) - 8'h01;
                    s_nxt.st = BC_ACT;
                end
            end
            BC_ACT:
            begin
                if (s_r.cnt != 8'h00)
                begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
                else
                begin
                    // Data stays driven through recovery for hold time
                    if (!s_r.wr)
                    begin
                        s_nxt.rdata = fl_dq_i;
                    end
                    s_nxt.we_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.ce_n = 1'b1;
                    s_nxt.cnt = fpes_pkg::RECOV_CYC - 8'h01;
                    s_nxt.st = BC_REC;
                end
            end
            BC_REC:
            begin
                if (s_r.cnt != 8'h00)
                begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
                else
                begin
                    s_nxt.dq_oe_n = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = BC_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = BC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_r <= '{st: BC_IDLE, wr: 1'b0, cnt: 8'h00, done: 1'b0,
                     rdata: 16'h0000, addr: 21'h000000, dq: 16'h0000,
                     dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
    assign rdata = s_r.rdata;
    assign fl_addr = s_r.addr;
    assign fl_dq_o = s_r.dq;
    assign fl_dq_oe_n = s_r.dq_oe_n;
    assign fl_ce_n = s_r.ce_n;
    assign fl_oe_n = s_r.oe_n;
    assign fl_we_n = s_r.we_n;

endmodule : fpes_bus_cycle

// file: fpes_host.sv
module fpes_host #(
    parameter logic [7:0] CLR_STATUS_CMD = 8'h50
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic [15:0] fl_dq_i,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe_n,
    output logic [20:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);

    typedef enum logic [5:0] {
        HS_IDLE = 6'b000001,
        HS_CMD1 = 6'b000010,
        HS_CMD2 = 6'b000100,
        HS_POLL = 6'b001000,
        HS_ARRD = 6'b010000,
        HS_EXIT = 6'b100000
    } fpes_hs_st_t;

    typedef struct packed {
        fpes_hs_st_t st;
        fpes_pkg::fpes_op_t op;
        logic chk;
        logic ext;
        logic alt;
        logic wt;
        logic [20:0] addr;
        logic [15:0] wdata;
        logic [7:0] flsr;
        logic [3:0] errs;
        logic err_pend;
        logic [15:0] rdata;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic [31:0] rd_data;
        logic irq;
        logic req;
        logic req_wr;
        logic [20:0] req_addr;
        logic [15:0] req_data;
    } fpes_host_t;

    fpes_host_t s_r;
    fpes_host_t s_nxt;
    logic bc_done;
    logic [15:0] bc_rdata;

    fpes_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .reset(reset),
        .req(s_r.req),
        .req_wr(s_r.req_wr),
        .req_addr(s_r.req_addr),
        .req_data(s_r.req_data),
        .fl_dq_i(fl_dq_i),
        .done(bc_done),
        .rdata(bc_rdata),
        .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe_n(fl_dq_oe_n),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n)
    );

    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic [15:0] cmd2_data;
    logic has_cmd2;
    logic do_poll;
    logic is_modify;
    logic [3:0] new_errs;
    logic [2:0] ev;
    logic [7:0] sr;
    fpes_pkg::fpes_op_t wop;
    logic wop_ok;

    // ****************************************
    // Command bytes for the current operation
    // ****************************************
    always_comb
    begin
        cmd1 = fpes_pkg::FL_READ_ARRAY;
        cmd2 = fpes_pkg::FL_CONFIRM;
        has_cmd2 = 1'b0;
        do_poll = 1'b0;
        case (s_r.op)
            fpes_pkg::OP_PROG:
            begin
                cmd1 = s_r.alt ? fpes_pkg::FL_PROG_SETUP_ALT
                               : fpes_pkg::FL_PROG_SETUP;
                has_cmd2 = 1'b1;
                do_poll = 1'b1;
            end
            fpes_pkg::OP_ERASE_ALL:
            begin
                cmd1 = fpes_pkg::FL_ERASE_ALL_SETUP;
                has_cmd2 = 1'b1;
                do_poll = 1'b1;
            end
            fpes_pkg::OP_LOCK_SET:
            begin
                // One pair per block; software repeats for a series
                cmd1 = fpes_pkg::FL_LOCK_SETUP;
                cmd2 = fpes_pkg::FL_LOCK_SET;
                has_cmd2 = 1'b1;
                do_poll = 1'b1;
            end
            fpes_pkg::OP_LOCK_CLR:
            begin
                cmd1 = fpes_pkg::FL_LOCK_SETUP;
                has_cmd2 = 1'b1;
                do_poll = 1'b1;
            end
            fpes_pkg::OP_CLR_STATUS:
            begin
                cmd1 = CLR_STATUS_CMD;
            end
            fpes_pkg::OP_READ_STATUS:
            begin
                cmd1 = fpes_pkg::FL_READ_STATUS;
                do_poll = 1'b1;
            end
            default:
            begin
                cmd1 = fpes_pkg::FL_READ_ARRAY;
            end
        endcase
        // Program data goes to the same location as its setup
        cmd2_data = (s_r.op == fpes_pkg::OP_PROG) ? s_r.wdata
                                                  : {8'h00, cmd2};
    end

    // ****************************************
    // Status decode once the part reports ready
    // ****************************************
    always_comb
    begin
        sr = bc_rdata[7:0];
        new_errs = 4'h0;
        new_errs[fpes_pkg::ERR_VPP] = sr[fpes_pkg::SR_VPP_LOW];
        new_errs[fpes_pkg::ERR_PROT] = sr[fpes_pkg::SR_PROTECT];
        new_errs[fpes_pkg::ERR_SEQ] = sr[fpes_pkg::SR_ERASE_ERR]
                                    & sr[fpes_pkg::SR_WRITE_ERR];
        case (s_r.op)
            fpes_pkg::OP_ERASE_ALL, fpes_pkg::OP_LOCK_CLR:
            begin
                new_errs[fpes_pkg::ERR_OP] = sr[fpes_pkg::SR_ERASE_ERR]
                    & ~new_errs[fpes_pkg::ERR_SEQ];
            end
            fpes_pkg::OP_PROG, fpes_pkg::OP_LOCK_SET:
            begin
                new_errs[fpes_pkg::ERR_OP] = sr[fpes_pkg::SR_WRITE_ERR]
                    & ~new_errs[fpes_pkg::ERR_SEQ];
            end
            default:
            begin
                new_errs[fpes_pkg::ERR_OP] = (sr[fpes_pkg::SR_ERASE_ERR]
                    | sr[fpes_pkg::SR_WRITE_ERR])
                    & ~new_errs[fpes_pkg::ERR_SEQ];
            end
        endcase
        wop = fpes_pkg::fpes_op_t'(reg_wdata[3:0]);
        is_modify = (wop == fpes_pkg::OP_PROG)
                  || (wop == fpes_pkg::OP_ERASE_ALL)
                  || (wop == fpes_pkg::OP_LOCK_SET)
                  || (wop == fpes_pkg::OP_LOCK_CLR);
        wop_ok = is_modify || (wop == fpes_pkg::OP_READ_MODE)
               || (wop == fpes_pkg::OP_CLR_STATUS)
               || (wop == fpes_pkg::OP_READ_STATUS)
               || (wop == fpes_pkg::OP_ARRAY_READ);
    end

    // ****************************************
    // Sequencer and register file
    // ****************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.req = 1'b0;
        ev = 3'b000;
        case (s_r.st)
            HS_IDLE:
            begin
                if (reg_wr && reg_addr == fpes_pkg::REG_CMD)
                begin
                    // A new modify is refused while an error is pending, until a clear status
                    if (!wop_ok || (is_modify && s_r.err_pend))
                    begin
                        ev[fpes_pkg::IRQ_REFUSED] = 1'b1;
                    end
                    else
                    begin
                        s_nxt.op = wop;
                        s_nxt.chk = reg_wdata[fpes_pkg::CMD_CHECK];
                        s_nxt.ext = reg_wdata[fpes_pkg::CMD_EXIT];
                        s_nxt.alt = reg_wdata[fpes_pkg::CMD_ALT];
                        s_nxt.st = (wop == fpes_pkg::OP_ARRAY_READ)
                                 ? HS_ARRD : HS_CMD1;
                    end
                end
            end
            HS_CMD1, HS_CMD2, HS_EXIT:
            begin
                if (!s_r.wt)
                begin
                    s_nxt.req = 1'b1;
                    s_nxt.req_wr = 1'b1;
                    s_nxt.req_addr = s_r.addr;
                    s_nxt.req_data = (s_r.st == HS_CMD2) ? cmd2_data
                        : {8'h00, (s_r.st == HS_EXIT)
                                  ? fpes_pkg::FL_READ_ARRAY : cmd1};
                    s_nxt.wt = 1'b1;
                end
                else if (bc_done)
                begin
                    s_nxt.wt = 1'b0;
                    if (s_r.st == HS_CMD1 && has_cmd2)
                    begin
                        s_nxt.st = HS_CMD2;
                    end
                    else if (s_r.st != HS_EXIT && do_poll)
                    begin
                        s_nxt.st = HS_POLL;
                    end
                    else
                    begin
                        if (s_r.op == fpes_pkg::OP_CLR_STATUS)
                        begin
                            s_nxt.errs = 4'h0;
                            s_nxt.err_pend = 1'b0;
                        end
                        ev[fpes_pkg::IRQ_DONE] = 1'b1;
                        s_nxt.st = HS_IDLE;
                    end
                end
            end
            HS_POLL, HS_ARRD:
            begin
                if (!s_r.wt)
                begin
                    // After confirm, plain reads return status
                    s_nxt.req = 1'b1;
                    s_nxt.req_wr = 1'b0;
                    s_nxt.req_addr = s_r.addr;
                    s_nxt.wt = 1'b1;
                end
                else if (bc_done)
                begin
                    s_nxt.wt = 1'b0;
                    if (s_r.st == HS_ARRD)
                    begin
                        s_nxt.rdata = bc_rdata;
                        ev[fpes_pkg::IRQ_DONE] = 1'b1;
                        s_nxt.st = HS_IDLE;
                    end
                    // Busy answers carry no valid low bits
                    else if (sr[fpes_pkg::SR_READY])
                    begin
                        s_nxt.flsr = sr;
                        if (s_r.chk && new_errs != 4'h0)
                        begin
                            // Errors pile up like the part's own bits
                            s_nxt.errs = s_r.errs | new_errs;
                            s_nxt.err_pend = 1'b1;
                            ev[fpes_pkg::IRQ_ERR] = 1'b1;
                        end
                        if (s_r.ext)
                        begin
                            s_nxt.st = HS_EXIT;
                        end
                        else
                        begin
                            ev[fpes_pkg::IRQ_DONE] = 1'b1;
                            s_nxt.st = HS_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                s_nxt.st = HS_IDLE;
            end
        endcase
        if (reg_wr && reg_addr == fpes_pkg::REG_CMD && s_r.st != HS_IDLE)
        begin
            ev[fpes_pkg::IRQ_REFUSED] = 1'b1;
        end
        if (reg_wr && reg_addr == fpes_pkg::REG_ADDR)
        begin
            s_nxt.addr = reg_wdata[20:0];
        end
        if (reg_wr && reg_addr == fpes_pkg::REG_WDATA)
        begin
            s_nxt.wdata = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == fpes_pkg::REG_INT_EN)
        begin
            s_nxt.irq_en = reg_wdata[2:0];
        end
        // A fresh event beats a clear in the same cycle
        if (reg_wr && reg_addr == fpes_pkg::REG_INT_CLR)
        begin
            s_nxt.irq_st = (s_r.irq_st & ~reg_wdata[2:0]) | ev;
        end
        else
        begin
            s_nxt.irq_st = s_r.irq_st | ev;
        end
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
        s_nxt.rd_data = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                fpes_pkg::REG_CMD:
                    s_nxt.rd_data = {25'h0000000, s_r.alt, s_r.ext, s_r.chk,
                                     s_r.op};
                fpes_pkg::REG_ADDR:
                    s_nxt.rd_data = {11'h000, s_r.addr};
                fpes_pkg::REG_WDATA:
                    s_nxt.rd_data = {16'h0000, s_r.wdata};
                fpes_pkg::REG_STATUS:
                    s_nxt.rd_data = {16'h0000, s_r.flsr, s_r.errs, 2'b00,
                                     s_r.err_pend, s_r.st != HS_IDLE};
                fpes_pkg::REG_RDATA:
                    s_nxt.rd_data = {16'h0000, s_r.rdata};
                fpes_pkg::REG_INT_STAT:
                    s_nxt.rd_data = {29'h00000000, s_r.irq_st};
                fpes_pkg::REG_INT_EN:
                    s_nxt.rd_data = {29'h00000000, s_r.irq_en};
                default:
                    s_nxt.rd_data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_r <= '{st: HS_IDLE, op: fpes_pkg::OP_NONE, chk: 1'b0,
                     ext: 1'b0, alt: 1'b0, wt: 1'b0, addr: 21'h000000,
                     wdata: 16'h0000, flsr: 8'h00, errs: 4'h0,
                     err_pend: 1'b0, rdata: 16'h0000, irq_st: 3'h0,
                     irq_en: 3'h0, rd_data: 32'h00000000, irq: 1'b0,
                     req: 1'b0, req_wr: 1'b0, req_addr: 21'h000000,
                     req_data: 16'h0000};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rd_data;
    assign irq = s_r.irq;

endmodule : fpes_host

// file: fpes_host_properties.sv
module fpes_host_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe_n,
    input wire logic [20:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    AST_RST_QUIET: assert property (disable iff (1'b0)
        reset |=> reg_rdata == 32'h0 && !irq && fl_ce_n && fl_we_n)
        else $error("outputs not idle after reset");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    AST_WE_SELECTS: assert property (!fl_we_n |-> !fl_ce_n && !fl_dq_oe_n)
        else $error("write strobe without select or data");
    AST_NO_CONTENTION: assert property (!fl_dq_oe_n |-> fl_oe_n)
        else $error("output enable while host drives data");
    AST_WE_WIDTH: assert property ($fell(fl_we_n) |=> !fl_we_n ##1 fl_we_n)
        else $error("write strobe not two cycles");
    AST_OE_WIDTH: assert property ($fell(fl_oe_n) |-> !fl_oe_n[*4] ##1 fl_oe_n)
        else $error("read strobe not four cycles");
    AST_DATA_HOLD: assert property ($rose(fl_we_n) |->
        ($stable(fl_dq_o) && !fl_dq_oe_n)[*2] ##1 fl_dq_oe_n)
        else $error("write data not held in recovery");
    AST_ADDR_HOLD: assert property (!fl_ce_n && !$past(fl_ce_n) |->
        $stable(fl_addr))
        else $error("address moved during cycle");

    COV_WRITE: cover property ($fell(fl_we_n));
    COV_READ: cover property ($fell(fl_oe_n));
    COV_IRQ: cover property ($rose(irq));
endmodule : fpes_host_properties

bind fpes_host fpes_host_properties u_props (.sys_clk(sys_clk),
    .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// file: fpes_flash_model.sv
module fpes_flash_model (
    input wire logic [20:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic [2:0] inject,
    output logic [15:0] fl_dq_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sr_r = 8'h80;
    logic [7:0] setup_r = 8'h00;
    logic [20:0] sa_r = 21'h0;
    logic stat_r = 1'b0;
    logic [1:0] busy_r = 2'd0;
    logic [15:0] last_r = 16'h0;
    logic [15:0] mem_r [16];
    logic [15:0] rd_v;
    logic wsel = 1'b0;

    // Errors only ever OR in, so a series keeps them
    task automatic fin(input logic [7:0] m, input logic seq);
        if (inject[0]) sr_r = sr_r | m | 8'h08;
        if (inject[1]) sr_r = sr_r | m | 8'h02;
        if (inject[2] || seq) sr_r = sr_r | 8'h30;
        busy_r = 2'd2;
        stat_r = 1'b1;
        setup_r = 8'h00;
    endtask : fin

    // Select and strobe rise together, so a write is armed at its fall
    always @(negedge fl_we_n) wsel = 1'b1;

    always @(posedge fl_we_n)
    if (wsel)
    begin
        wsel = 1'b0;
        case (setup_r)
            8'h40, 8'h10:
            begin
                mem_r[fl_addr[3:0]] = fl_dq_o;
                fin(8'h10, fl_addr != sa_r);
            end
            8'h30: fin(8'h20, fl_dq_o[7:0] != 8'hd0);
            8'h60: fin(fl_dq_o[7:0] == 8'h01 ? 8'h10 : 8'h20,
                fl_dq_o[7:0] != 8'h01 && fl_dq_o[7:0] != 8'hd0);
            default:
            begin
                sa_r = fl_addr;
                stat_r = fl_dq_o[7:0] != 8'hff;
                if (fl_dq_o[7:0] == 8'h50) sr_r = 8'h80;
                else if (fl_dq_o[7:0] != 8'h70) setup_r = fl_dq_o[7:0];
            end
        endcase
    end

    // Busy status carries junk low bits, host must mask them
    assign rd_v = !stat_r ? mem_r[fl_addr[3:0]] : busy_r != 2'd0 ?
        {9'h0, ~sr_r[6:0]} : {8'h00, sr_r};
    // No pull-up: a released bus shows the inverse of the last value
    assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rd_v : ~last_r;

    always @(posedge fl_oe_n)
    begin
        last_r = rd_v;
        if (stat_r && busy_r != 2'd0) busy_r = busy_r - 2'd1;
    end
endmodule : fpes_flash_model

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    logic [15:0] fl_dq_i, fl_dq_o;
    logic [20:0] fl_addr;
    logic fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
    logic [2:0] inject = 3'h0;
    logic [31:0] st;
    int n_errors = 0;
    int checks_done = 0;

    fpes_host u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .fl_dq_i(fl_dq_i),
        .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
    fpes_flash_model u_flash (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .inject(inject), .fl_dq_i(fl_dq_i));

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ********
    // Bus tasks
    // ********
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 st = reg_rdata;
    endtask : rd

    // Bounded poll, a hang counts as a mismatch
    task automatic idle();
        for (int i = 0; i < 300; i++)
        begin
            rd(fpes_pkg::REG_STATUS);
            if (st[0] === 1'b0) break;
        end
        if (st[0] !== 1'b0)
        begin
            n_errors++;
            $display("BAD %0t busy stuck", $time);
            tally_and_finish();
        end
    endtask : idle

    task automatic run(input logic [2:0] inj, input fpes_pkg::fpes_op_t op,
        input logic [2:0] b, input logic [7:0] sr, input logic [3:0] fl);
        inject <= inj;
        wr(fpes_pkg::REG_CMD, {25'h0, b, op});
        idle();
        chk(st[15:8], sr);
        if (b[0]) chk(st[7:4], fl);
    endtask : run

    task automatic clr(input logic [7:0] s);
        run(3'h0, fpes_pkg::OP_CLR_STATUS, 3'h0, s, 4'h0);
        chk(st[7:1], 7'h0);
        wr(fpes_pkg::REG_INT_CLR, 32'h7);
        rd(fpes_pkg::REG_STATUS);
        chk(irq, 1'b0);
    endtask : clr

    task automatic arr(input logic [15:0] d);
        run(3'h0, fpes_pkg::OP_ARRAY_READ, 3'h0, st[15:8], 4'h0);
        rd(fpes_pkg::REG_RDATA);
        chk(st, {16'h0, d});
    endtask : arr

    // ********
    // Scenarios
    // ********
    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h2c);
        chk(st, 32'h0);
        wr(fpes_pkg::REG_INT_EN, 32'h6);
        wr(fpes_pkg::REG_ADDR, 32'h5);
        wr(fpes_pkg::REG_WDATA, 32'h1234);
        run(3'h0, fpes_pkg::OP_PROG, 3'b011, 8'h80, 4'h0);
        arr(16'h1234);
        wr(fpes_pkg::REG_ADDR, 32'h6);
        wr(fpes_pkg::REG_WDATA, 32'habcd);
        run(3'h0, fpes_pkg::OP_PROG, 3'b111, 8'h80, 4'h0);
        arr(16'habcd);
        run(3'h0, fpes_pkg::OP_READ_STATUS, 3'h0, 8'h80, 4'h0);
        run(3'h0, fpes_pkg::OP_READ_MODE, 3'h0, 8'h80, 4'h0);
        arr(16'habcd);
        chk(irq, 1'b0);
        run(3'h1, fpes_pkg::OP_ERASE_ALL, 3'b001, 8'ha8, 4'h9);
        chk(irq, 1'b1);
        wr(fpes_pkg::REG_CMD, 32'h1);
        rd(fpes_pkg::REG_INT_STAT);
        chk(st[2:1], 2'b11);
        clr(8'ha8);
        run(3'h2, fpes_pkg::OP_LOCK_SET, 3'b001, 8'h92, 4'ha);
        clr(8'h92);
        run(3'h4, fpes_pkg::OP_LOCK_CLR, 3'b001, 8'hb0, 4'h4);
        clr(8'hb0);
        run(3'h1, fpes_pkg::OP_ERASE_ALL, 3'h0, 8'ha8, 4'h0);
        run(3'h0, fpes_pkg::OP_ERASE_ALL, 3'b001, 8'ha8, 4'h9);
        clr(8'ha8);
        run(3'h1, fpes_pkg::OP_PROG, 3'h0, 8'h98, 4'h0);
        run(3'h0, fpes_pkg::OP_PROG, 3'b001, 8'h98, 4'h9);
        clr(8'h98);
        run(3'h1, fpes_pkg::OP_LOCK_SET, 3'h0, 8'h98, 4'h0);
        run(3'h0, fpes_pkg::OP_LOCK_SET, 3'b001, 8'h98, 4'h9);
        clr(8'h98);
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : tb_top
